/* File: pkg/irf_map.svh */
`ifndef IRF_MAP_SVH
`define IRF_MAP_SVH
// register byte offsets
`define IRF_OFF_CFG 8'h00
`define IRF_OFF_SETUP 8'h04
`define IRF_OFF_CMD 8'h08
`define IRF_OFF_OWN 8'h0C
`define IRF_OFF_PROBE 8'h10
`define IRF_OFF_SUCC 8'h14
`define IRF_OFF_STAT 8'h18
`define IRF_OFF_MASK 8'h1C
`define IRF_OFF_FLAGS 8'h20
`define IRF_OFF_RAM0 8'h24
`define IRF_OFF_RAM1 8'h28
// configuration bits
`define IRF_CFG_BYPASS 0
`define IRF_CFG_REFINE 1
`define IRF_CFG_SRST 2
// status and mask bits
`define IRF_ST_TX 0
`define IRF_ST_RX 1
`define IRF_ST_INIT 2
`define IRF_ST_REJ 3
// command codes
`define IRF_CMD_CLRINT 8'h01
`define IRF_CMD_CLRFLAG 8'h02
`define IRF_CMD_ENTX 8'h03
`define IRF_CMD_ENRX 8'h04
// init contents
`define IRF_INIT_MARK 8'hD1
`define IRF_NODE_ZERO 8'h00
// timing
`define IRF_CLK_NS 40
`define IRF_INIT_US 96
`define IRF_INIT_CYC ((`IRF_INIT_US * 1000) / `IRF_CLK_NS)
`define IRF_DIS_NS 200
`define IRF_DIS_CYC ((`IRF_DIS_NS / `IRF_CLK_NS) + 1)
`define IRF_CMD_NS 100
`define IRF_CMD_CYC ((`IRF_CMD_NS + `IRF_CLK_NS - 1) / `IRF_CLK_NS)
`define IRF_OS_NS 400
`define IRF_OS_CYC (`IRF_OS_NS / `IRF_CLK_NS)
`define IRF_CMD_TICKS 3
`define IRF_WIN_TICKS 4
`endif

/* File: pkg/irf_pkg.sv */
`include "irf_map.svh"
package irf_pkg;
    // classic wishbone request bundle
    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [3:0] sel;
        logic [7:0] adr;
        logic [31:0] dat;
    } irf_wbreq_s;
    // init micro-program position, gray along its path
    typedef enum logic [1:0] {
        INIT_IDLE = 2'h0,
        INIT_WAIT = 2'h1,
        INIT_WR0 = 2'h3,
        INIT_WR1 = 2'h2
    } irf_init_e;
endpackage

/* File: design/irf_top.sv */
// Register access over Wishbone and the register addresses were decided locally.
`timescale 1ns/100ps
`default_nettype none
`include "irf_map.svh"
module irf_top
    import irf_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    input wire irf_wbreq_s wbReq,
    output logic [31:0] wbDatO,
    output logic wbAck,
    input wire logic lineIdle,
    input wire logic txDoneEvent,
    input wire logic rxInhibitEvent,
    input wire logic probeMatch,
    input wire logic dupMatch,
    input wire logic [7:0] successorNode,
    output logic interruptOutN,
    output logic oversampleTick,
    output logic transmitDoneFlag,
    output logic receiveInhibitFlag
);

    // address match, used for register writes and the successor and status reads
    function automatic logic isReg(input logic [7:0] adr, input logic [7:0] off);
        return adr == off;
    endfunction

    // program-counter decode: inside the init routine
    function automatic logic inInit(input irf_init_e s);
        return s != INIT_IDLE;
    endfunction

    logic access; // new request, not yet acked
    logic wrEn; // write strobe, low lane enabled
    logic rdEn; // read strobe
    logic [7:0] wrData; // low byte of write data
    logic [7:0] cfgReg; // configuration bits
    logic [2:0] rateSelReg; // rate_prescale_select field
    logic [7:0] ownStationReg; // node identifier
    logic [7:0] probeNodeReg; // probe own_station_reg
    logic [3:0] statusReg; // sticky events
    logic [3:0] maskReg; // interrupt mask
    logic bypass; // line_idle_bypass
    logic refine; // refinement_enable
    logic softNow; // soft reset this cycle
    logic ownWr; // write to own_station_reg
    logic probeWr; // write to probe id
    logic succRd; // read of successor
    logic statRd; // read of status

    assign access = wbReq.cyc & wbReq.stb & ~wbAck;
    assign wrEn = access & wbReq.we & wbReq.sel[0];
    assign rdEn = access & ~wbReq.we;
    assign wrData = wbReq.dat[7:0];
    assign bypass = cfgReg[`IRF_CFG_BYPASS];
    assign refine = cfgReg[`IRF_CFG_REFINE];
    assign ownWr = wrEn & isReg(wbReq.adr, `IRF_OFF_OWN);
    assign probeWr = wrEn & isReg(wbReq.adr, `IRF_OFF_PROBE);
    assign succRd = rdEn & isReg(wbReq.adr, `IRF_OFF_SUCC);
    assign statRd = rdEn & isReg(wbReq.adr, `IRF_OFF_STAT);
    // soft reset: own_station_reg to zero or reset bit high
    assign softNow = (ownWr & (wrData == `IRF_NODE_ZERO)) | cfgReg[`IRF_CFG_SRST];

    // bus acknowledge, one cycle after request
    always_ff @(posedge clk) begin
        if (reset) begin
            wbAck <= 1'b0;
        end else begin
            wbAck <= access;
        end
    end

    // configuration and setup registers
    always_ff @(posedge clk) begin
        if (reset) begin
            cfgReg <= 8'h00;
            rateSelReg <= 3'h0;
        end else if (wrEn && isReg(wbReq.adr, `IRF_OFF_CFG)) begin
            cfgReg <= wrData;
        end else if (wrEn && isReg(wbReq.adr, `IRF_OFF_SETUP)) begin
            rateSelReg <= wrData[2:0];
        end
    end

    // own_station_reg and probe id registers
    always_ff @(posedge clk) begin
        if (reset) begin
            ownStationReg <= 8'h00;
            probeNodeReg <= 8'h00;
        end else begin
            if (ownWr) begin
                ownStationReg <= wrData;
            end
            if (probeWr) begin
                probeNodeReg <= wrData;
            end
        end
    end

    // line idle pin synchroniser
    logic lineSync1;
    logic lineSync2;
    always_ff @(posedge clk) begin
        if (reset) begin
            lineSync1 <= 1'b0;
            lineSync2 <= 1'b0;
        end else begin
            lineSync1 <= lineIdle;
            lineSync2 <= lineSync1;
        end
    end

    // prescaler: oversample tick at 8x the data rate
    logic [15:0] osCnt; // cycles to next tick
    logic [2:0] rateSync1; // rate select, first stage
    logic [2:0] rateSync2; // rate select, second stage
    logic [2:0] rateEff; // rate in force
    logic [15:0] osPeriod; // cycles per tick
    logic osTickNow; // tick this cycle
    assign rateEff = refine ? rateSync2 : rateSelReg;
    assign osPeriod = 16'(`IRF_OS_CYC) << rateEff;
    assign osTickNow = (osCnt == 16'h0000);

    // rate select moves only at prescaler reload when refined
    always_ff @(posedge clk) begin
        if (reset) begin
            rateSync1 <= 3'h0;
            rateSync2 <= 3'h0;
        end else if (osTickNow) begin
            rateSync1 <= rateSelReg;
            rateSync2 <= rateSync1;
        end
    end

    // prescaler counter
    always_ff @(posedge clk) begin
        if (reset) begin
            osCnt <= 16'h0000;
            oversampleTick <= 1'b0;
        end else begin
            osCnt <= osTickNow ? osPeriod - 16'h0001 : osCnt - 16'h0001;
            oversampleTick <= osTickNow;
        end
    end

    // command write spacing and decode
    logic cmdWr; // any command write
    logic cmdBusy; // spacing not yet over
    logic cmdOk; // command accepted
    logic cmdRej; // command refused
    logic [3:0] gapCnt; // spacing counter
    logic [1:0] window; // enable prohibition per flag
    logic [1:0] enCmd; // accepted enable per flag
    logic [1:0] enReq; // enable requested per flag
    logic clrInt; // clear tx/rx interrupt
    logic clrFlag; // clear flag command
    assign cmdWr = wrEn & isReg(wbReq.adr, `IRF_OFF_CMD);
    assign cmdBusy = gapCnt != 4'h0;
    assign enReq[0] = cmdWr & (wrData == `IRF_CMD_ENTX);
    assign enReq[1] = cmdWr & (wrData == `IRF_CMD_ENRX);
    // legacy enable command during window is refused
    assign cmdRej = cmdWr & (cmdBusy | (|(enReq & window)));
    assign cmdOk = cmdWr & ~cmdRej;
    assign enCmd = enReq & {2{cmdOk}};
    assign clrInt = cmdOk & (wrData == `IRF_CMD_CLRINT);
    assign clrFlag = cmdOk & (wrData == `IRF_CMD_CLRFLAG);

    // spacing: crystal cycles when refined, oversample ticks otherwise
    always_ff @(posedge clk) begin
        if (reset) begin
            gapCnt <= 4'h0;
        end else if (cmdOk) begin
            gapCnt <= refine ? 4'(`IRF_CMD_CYC - 1) : 4'(`IRF_CMD_TICKS);
        end else if (cmdBusy && (refine || osTickNow)) begin
            gapCnt <= gapCnt - 4'h1;
        end
    end

    // transmit-done and receive-inhibit flags
    logic [1:0] flagReg; // flag levels
    logic [1:0] flagPrev; // last cycle levels
    logic [1:0] flagRise; // flag returned high
    logic [1:0] setEvt; // setting pulse start
    logic [2:0] pulseCnt [2]; // setting pulse length
    assign setEvt = {rxInhibitEvent, txDoneEvent};
    assign flagRise = flagReg & ~flagPrev;
    for (genvar i = 0; i < 2; i++) begin : gFlag
        assign window[i] = ~refine & (pulseCnt[i] != 3'h0);
        // one flag: setting pulse and level
        always_ff @(posedge clk) begin
            if (reset) begin
                flagReg[i] <= 1'b1;
                pulseCnt[i] <= 3'h0;
            end else begin
                if (setEvt[i]) begin
                    pulseCnt[i] <= 3'(`IRF_WIN_TICKS);
                end else if (osTickNow && pulseCnt[i] != 3'h0) begin
                    pulseCnt[i] <= pulseCnt[i] - 3'h1;
                end
                if (softNow) begin
                    flagReg[i] <= 1'b1;
                end else if (setEvt[i] && !refine) begin
                    flagReg[i] <= 1'b1;
                end else if (refine && osTickNow && pulseCnt[i] == 3'h1) begin
                    flagReg[i] <= 1'b1;
                end else if (enCmd[i]) begin
                    flagReg[i] <= 1'b0;
                end
            end
        end
    end

    // flag outputs and edge history
    always_ff @(posedge clk) begin
        if (reset) begin
            flagPrev <= 2'h3;
        end else begin
            flagPrev <= flagReg;
        end
    end
    assign transmitDoneFlag = flagReg[0];
    assign receiveInhibitFlag = flagReg[1];

    // init micro-program and its two ram words
    irf_init_e initState;
    logic [7:0] initRam [2]; // locations 000h and 001h
    always_ff @(posedge clk) begin
        if (reset) begin
            initState <= INIT_IDLE;
        end else begin
            unique case (initState)
                INIT_IDLE: begin
                    if (ownWr) begin
                        initState <= INIT_WAIT;
                    end
                end
                INIT_WAIT: begin
                    // line wait suppressed by bypass inside the routine
                    if (lineSync2 || (bypass && inInit(initState))) begin
                        initState <= INIT_WR0;
                    end
                end
                INIT_WR0: initState <= INIT_WR1;
                INIT_WR1: initState <= INIT_IDLE;
            endcase
        end
    end

    // ram writes of the init routine
    always_ff @(posedge clk) begin
        if (reset) begin
            initRam[0] <= 8'h00;
            initRam[1] <= 8'h00;
        end else if (initState == INIT_WR0) begin
            initRam[0] <= `IRF_INIT_MARK;
        end else if (initState == INIT_WR1) begin
            initRam[1] <= ownStationReg;
        end
    end

    // probe and duplicate check residue
    logic probeHit; // probe node answered
    logic dupHit; // duplicate_check_reg seen
    logic lateClr; // legacy delayed clear
    logic idWr; // probe or own_station_reg write
    assign idWr = probeWr | ownWr;
    always_ff @(posedge clk) begin
        if (reset) begin
            probeHit <= 1'b0;
            dupHit <= 1'b0;
            lateClr <= 1'b0;
        end else begin
            // legacy residue lingers until next tick
            lateClr <= (idWr & ~refine) | (lateClr & ~osTickNow);
            if (probeMatch) begin
                probeHit <= 1'b1;
            end else if ((idWr && refine) || (lateClr && osTickNow)) begin
                probeHit <= 1'b0;
            end
            if (dupMatch) begin
                dupHit <= 1'b1;
            end else if ((idWr && refine) || (lateClr && osTickNow)) begin
                dupHit <= 1'b0;
            end
        end
    end

    // sticky status: set wins, status read clears
    logic [3:0] stSet; // events this cycle
    logic [3:0] stClr; // clears this cycle
    assign stSet = {cmdRej, initState == INIT_WR1, flagRise};
    assign stClr = {4{statRd}} | {{2{clrFlag}}, {2{clrInt}}};
    always_ff @(posedge clk) begin
        if (reset) begin
            statusReg <= 4'h0;
        end else begin
            statusReg <= (statusReg & ~stClr) | stSet;
        end
    end

    // mask: soft reset clears it only when refined
    always_ff @(posedge clk) begin
        if (reset) begin
            maskReg <= 4'h0;
        end else if (softNow && refine) begin
            maskReg <= 4'h0;
        end else if (wrEn && isReg(wbReq.adr, `IRF_OFF_MASK)) begin
            maskReg <= wrData[3:0];
        end
    end

    // interrupt disable timer
    logic [15:0] disCnt; // cycles interrupt held off
    logic disTrig; // disabling access
    assign disTrig = (clrInt | clrFlag | succRd) & ~interruptOutN;
    always_ff @(posedge clk) begin
        if (reset) begin
            disCnt <= 16'h0000;
        end else if (disTrig) begin
            disCnt <= refine ? 16'(`IRF_DIS_CYC) : osPeriod;
        end else if (disCnt != 16'h0000) begin
            disCnt <= disCnt - 16'h0001;
        end
    end

    // active-low interrupt pin
    always_ff @(posedge clk) begin
        if (reset) begin
            interruptOutN <= 1'b1;
        end else begin
            interruptOutN <= ~((|(statusReg & maskReg)) & (disCnt == 16'h0000) & ~disTrig);
        end
    end

    // read data register, unmapped reads zero
    always_ff @(posedge clk) begin
        if (reset) begin
            wbDatO <= 32'h0000_0000;
        end else if (rdEn) begin
            unique case (wbReq.adr)
                `IRF_OFF_CFG: wbDatO <= {24'h000000, cfgReg};
                `IRF_OFF_SETUP: wbDatO <= {29'h0000_0000, rateSelReg};
                `IRF_OFF_OWN: wbDatO <= {24'h000000, ownStationReg};
                `IRF_OFF_PROBE: wbDatO <= {24'h000000, probeNodeReg};
                `IRF_OFF_SUCC: wbDatO <= {24'h000000, successorNode};
                `IRF_OFF_STAT: wbDatO <= {28'h0000000, statusReg};
                `IRF_OFF_MASK: wbDatO <= {28'h0000000, maskReg};
                `IRF_OFF_FLAGS: wbDatO <= {27'h0000000, inInit(initState), dupHit, probeHit, flagReg};
                `IRF_OFF_RAM0: wbDatO <= {24'h000000, initRam[0]};
                `IRF_OFF_RAM1: wbDatO <= {24'h000000, initRam[1]};
                default: wbDatO <= 32'h0000_0000;
            endcase
        end
    end

    // checks
    init_wait_a: assert property (@(posedge clk) disable iff (reset)
        initState == INIT_WAIT && !bypass && !lineSync2 |=> initState == INIT_WAIT)
        else $error("init left line wait on busy line");
    init_bypass_a: assert property (@(posedge clk) disable iff (reset)
        initState == INIT_WAIT && bypass |=> initState == INIT_WR0 ##2 initRam[0] == `IRF_INIT_MARK)
        else $error("bypassed init did not write marker");
    init_node_a: assert property (@(posedge clk) disable iff (reset)
        initState == INIT_WR1 |=> initRam[1] == $past(ownStationReg))
        else $error("own_station_reg not stored at second location");
    irq_off_a: assert property (@(posedge clk) disable iff (reset)
        disTrig |=> interruptOutN)
        else $error("interrupt not disabled");
    irq_hold_a: assert property (@(posedge clk) disable iff (reset)
        disTrig && refine |=> interruptOutN [*6])
        else $error("refined disable time too short");
    cmd_gap_a: assert property (@(posedge clk) disable iff (reset)
        cmdOk && refine |=> !cmdOk [*2])
        else $error("refined command spacing broken");
    cmd_slow_a: assert property (@(posedge clk) disable iff (reset)
        cmdOk && !refine |=> !cmdOk [*8])
        else $error("legacy command spacing broken");
    en_window_a: assert property (@(posedge clk) disable iff (reset)
        !refine && (|(enReq & window)) |-> cmdRej)
        else $error("enable accepted inside window");
    flag_late_a: assert property (@(posedge clk) disable iff (reset)
        refine && !$past(softNow) && flagRise[1] |-> $past(pulseCnt[1]) == 3'h1)
        else $error("refined flag returned early");
    rx_irq_a: assert property (@(posedge clk) disable iff (reset)
        flagRise[1] |=> statusReg[`IRF_ST_RX])
        else $error("receive flag return not flagged");
    mask_soft_a: assert property (@(posedge clk) disable iff (reset)
        softNow && refine |=> maskReg == 4'h0)
        else $error("mask survived soft reset");
    soft_flag_a: assert property (@(posedge clk) disable iff (reset)
        softNow |=> flagReg == 2'h3)
        else $error("soft reset left a flag low");
    probe_clr_a: assert property (@(posedge clk) disable iff (reset)
        idWr && refine && !probeMatch |=> !probeHit)
        else $error("probe residue not cleared");

endmodule
`default_nettype wire

/* File: testbench/irf_line_model.sv */
`timescale 1ns/100ps
`default_nettype none
module irf_line_model (
    input wire logic clk,
    input wire logic reset,
    input wire logic busyCmd,
    input wire logic [3:0] eventCmd,
    output logic lineIdle,
    output logic txDoneEvent,
    output logic rxInhibitEvent,
    output logic probeMatch,
    output logic dupMatch
);
    // line traffic as asked by the bench, idle after reset
    always_ff @(posedge clk) begin
        if (reset) begin
            lineIdle <= 1'h1;
        end else begin
            lineIdle <= ~busyCmd;
        end
    end
    // station events, each a one-cycle pulse
    always_ff @(posedge clk) begin
        if (reset) begin
            {dupMatch, probeMatch, rxInhibitEvent, txDoneEvent} <= 4'h0;
        end else begin
            {dupMatch, probeMatch, rxInhibitEvent, txDoneEvent} <= eventCmd;
        end
    end
endmodule
`default_nettype wire

/* File: testbench/testbench.sv */
`timescale 1ns/100ps
`default_nettype none
`include "irf_map.svh"
module testbench import irf_pkg::*;;
    // one queued read expectation
    typedef struct {
        logic [7:0] adr;
        logic [7:0] val;
        logic [7:0] msk;
    } irf_tbexp_s;
    logic clk = 1'h0; // bench clock
    logic reset; // synchronous reset
    irf_wbreq_s wbReq; // bus request
    logic [31:0] wbDatO;
    logic wbAck;
    logic lineIdle, txDoneEvent, rxInhibitEvent, probeMatch, dupMatch;
    logic [7:0] successorNode; // value shown at the successor register
    logic interruptOutN, oversampleTick, transmitDoneFlag, receiveInhibitFlag;
    logic busyCmd; // asks the line model for traffic
    logic [3:0] eventCmd; // asks the line model for events
    logic armW; // a disable gap is expected on the interrupt
    int hiCnt = 0; // cycles the interrupt has stood high
    int fails = 0;
    int nChecks = 0;
    int seed;
    irf_tbexp_s expQ[$]; // expected read results, oldest first
    irf_tbexp_s cur;
    logic [7:0] id;
    logic [31:0] tmp;
    // 25 MHz clock
    always #20 clk = ~clk;
    irf_top dut_u (.clk(clk), .reset(reset), .wbReq(wbReq), .wbDatO(wbDatO), .wbAck(wbAck),
        .lineIdle(lineIdle), .txDoneEvent(txDoneEvent), .rxInhibitEvent(rxInhibitEvent),
        .probeMatch(probeMatch), .dupMatch(dupMatch), .successorNode(successorNode),
        .interruptOutN(interruptOutN), .oversampleTick(oversampleTick),
        .transmitDoneFlag(transmitDoneFlag), .receiveInhibitFlag(receiveInhibitFlag));
    irf_line_model line_u (.clk(clk), .reset(reset), .busyCmd(busyCmd), .eventCmd(eventCmd),
        .lineIdle(lineIdle), .txDoneEvent(txDoneEvent), .rxInhibitEvent(rxInhibitEvent),
        .probeMatch(probeMatch), .dupMatch(dupMatch));
    // compare and count
    task automatic chk(input string what, input logic [31:0] got, input logic [31:0] exp);
        nChecks++;
        if (got !== exp) begin
            $display("ERROR %s expected %h seen %h", what, exp, got);
            fails++;
        end
    endtask
    // verdict and end of run
    task automatic endSim();
        $display("checks %0d fails %0d", nChecks, fails);
        if (fails == 0 && nChecks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    // one classic cycle: hold until ack, release, one idle cycle
    task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
        int n;
        n = 0;
        wbReq <= '{cyc: 1'h1, stb: 1'h1, we: w, sel: 4'hF, adr: a, dat: {24'h0, d}};
        do begin
            @(negedge clk);
            n++;
        end while (wbAck !== 1'h1 && n < 50);
        if (n >= 50) begin
            chk("ack wait", 32'h0, 32'h1);
        end
        @(posedge clk);
        wbReq <= '0;
        @(posedge clk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        bus(1'h1, a, d);
    endtask
    // read with a noted expectation under a mask
    task automatic rd(input logic [7:0] a, input logic [7:0] v, input logic [7:0] m);
        expQ.push_back('{adr: a, val: v, msk: m});
        bus(1'h0, a, 8'h00);
    endtask
    // one event pulse through the line model
    task automatic ev(input logic [3:0] m);
        eventCmd <= m;
        @(posedge clk);
        eventCmd <= 4'h0;
        @(posedge clk);
    endtask
    // bounded wait for an interrupt level
    task automatic waitIrq(input logic v);
        int n;
        n = 0;
        @(negedge clk);
        while (interruptOutN !== v && n < 100) begin
            @(negedge clk);
            n++;
        end
        chk("interrupt level", {31'h0, interruptOutN}, {31'h0, v});
        @(posedge clk);
    endtask
    // cycles between oversample ticks, after the change settles
    task automatic tickGap(input int gap);
        int n;
        repeat (4) begin
            n = 1;
            @(negedge clk);
            while (oversampleTick !== 1'h1 && n < 3000) begin
                @(negedge clk);
                n++;
            end
        end
        chk("tick gap", n, gap);
        @(posedge clk);
    endtask
    // read results taken from the queue as they appear
    always @(negedge clk) begin
        if (wbAck === 1'h1 && wbReq.we === 1'h0) begin
            if (expQ.size() == 0) begin
                chk("unexpected read", 32'h0, 32'h1);
            end else begin
                cur = expQ.pop_front();
                chk($sformatf("read %h", cur.adr), wbDatO & {24'h0, cur.msk}, {24'h0, cur.val & cur.msk});
            end
        end
    end
    // width of each high stretch of the interrupt
    always @(negedge clk) begin
        if (interruptOutN === 1'h1) begin
            hiCnt <= hiCnt + 1;
        end else begin
            if (armW && hiCnt != 0) begin
                chk("disable gap", {31'h0, hiCnt >= 6}, 32'h1);
                armW <= 1'h0;
            end
            hiCnt <= 0;
        end
    end
    // watchdog
    initial begin
        repeat (20000) @(posedge clk);
        fails++;
        endSim();
    end
    // main sequence
    initial begin
        seed = 32'hF45842AF;
        reset = 1'h1;
        wbReq = '0;
        busyCmd = 1'h0;
        eventCmd = 4'h0;
        armW = 1'h0;
        successorNode = 8'h00;
        repeat (20) @(posedge clk);
        reset <= 1'h0;
        successorNode <= 8'($random(seed));
        @(posedge clk);
        rd(`IRF_OFF_CFG, 8'h00, 8'hFF);
        rd(`IRF_OFF_FLAGS, 8'h03, 8'h1F);
        rd(`IRF_OFF_STAT, 8'h00, 8'hFF);
        wr(8'hFC, 8'hAA);
        rd(8'hFC, 8'h00, 8'hFF);
        // init held by a busy line, then done once idle
        id = 8'($random(seed)) | 8'h01;
        busyCmd <= 1'h1;
        repeat (4) @(posedge clk);
        wr(`IRF_OFF_OWN, id);
        repeat (30) @(posedge clk);
        rd(`IRF_OFF_FLAGS, 8'h10, 8'h10);
        busyCmd <= 1'h0;
        repeat (10) @(posedge clk);
        rd(`IRF_OFF_RAM0, 8'hD1, 8'hFF);
        rd(`IRF_OFF_RAM1, id, 8'hFF);
        rd(`IRF_OFF_STAT, 8'h04, 8'h04);
        // bypass lets init run on a busy line
        wr(`IRF_OFF_CFG, 8'h01);
        busyCmd <= 1'h1;
        repeat (4) @(posedge clk);
        id = 8'($random(seed)) | 8'h01;
        wr(`IRF_OFF_OWN, id);
        repeat (8) @(posedge clk);
        rd(`IRF_OFF_RAM0, 8'hD1, 8'hFF);
        rd(`IRF_OFF_RAM1, id, 8'hFF);
        rd(`IRF_OFF_CFG, 8'h01, 8'hFF);
        busyCmd <= 1'h0;
        // legacy timing: spacing, flag return, prohibition window
        wr(`IRF_OFF_CFG, 8'h00);
        repeat (40) @(posedge clk);
        rd(`IRF_OFF_STAT, 8'h04, 8'hFF);
        wr(`IRF_OFF_CMD, `IRF_CMD_CLRFLAG);
        wr(`IRF_OFF_CMD, `IRF_CMD_CLRFLAG);
        rd(`IRF_OFF_STAT, 8'h08, 8'h08);
        repeat (40) @(posedge clk);
        wr(`IRF_OFF_MASK, 8'h02);
        wr(`IRF_OFF_CMD, `IRF_CMD_ENRX);
        rd(`IRF_OFF_FLAGS, 8'h00, 8'h02);
        repeat (40) @(posedge clk);
        ev(4'h2);
        rd(`IRF_OFF_FLAGS, 8'h02, 8'h02);
        waitIrq(1'h0);
        wr(`IRF_OFF_CMD, `IRF_CMD_ENRX);
        rd(`IRF_OFF_FLAGS, 8'h02, 8'h02);
        rd(`IRF_OFF_STAT, 8'h0A, 8'h0A);
        // refined timing
        wr(`IRF_OFF_CFG, 8'h02);
        repeat (45) @(posedge clk);
        rd(`IRF_OFF_STAT, 8'h00, 8'hFF);
        wr(`IRF_OFF_CMD, `IRF_CMD_CLRFLAG);
        wr(`IRF_OFF_CMD, `IRF_CMD_CLRFLAG);
        rd(`IRF_OFF_STAT, 8'h00, 8'h08);
        wr(`IRF_OFF_CMD, `IRF_CMD_ENTX);
        wr(`IRF_OFF_CMD, `IRF_CMD_ENRX);
        ev(4'h3);
        rd(`IRF_OFF_FLAGS, 8'h00, 8'h03);
        repeat (45) @(posedge clk);
        rd(`IRF_OFF_FLAGS, 8'h03, 8'h03);
        rd(`IRF_OFF_STAT, 8'h03, 8'h03);
        wr(`IRF_OFF_CMD, `IRF_CMD_ENTX);
        rd(`IRF_OFF_FLAGS, 8'h00, 8'h01);
        rd(`IRF_OFF_STAT, 8'h00, 8'h08);
        // interrupt disabled by a successor read, then by clear
        wr(`IRF_OFF_MASK, 8'h01);
        ev(4'h1);
        repeat (45) @(posedge clk);
        waitIrq(1'h0);
        armW <= 1'h1;
        rd(`IRF_OFF_SUCC, successorNode, 8'hFF);
        waitIrq(1'h0);
        chk("disable gap seen", {31'h0, armW}, 32'h0);
        wr(`IRF_OFF_CMD, `IRF_CMD_CLRINT);
        repeat (10) @(posedge clk);
        @(negedge clk);
        chk("interrupt cleared", {31'h0, interruptOutN}, 32'h1);
        rd(`IRF_OFF_STAT, 8'h00, 8'h03);
        // residual probe and duplicate state
        ev(4'h4);
        rd(`IRF_OFF_FLAGS, 8'h04, 8'h04);
        wr(`IRF_OFF_PROBE, 8'h22);
        rd(`IRF_OFF_FLAGS, 8'h00, 8'h04);
        ev(4'h8);
        rd(`IRF_OFF_FLAGS, 8'h08, 8'h08);
        wr(`IRF_OFF_OWN, id);
        rd(`IRF_OFF_FLAGS, 8'h00, 8'h08);
        // soft reset, refined then legacy
        wr(`IRF_OFF_MASK, 8'h0F);
        wr(`IRF_OFF_CFG, 8'h06);
        wr(`IRF_OFF_CFG, 8'h02);
        rd(`IRF_OFF_MASK, 8'h00, 8'hFF);
        rd(`IRF_OFF_FLAGS, 8'h03, 8'h03);
        wr(`IRF_OFF_CFG, 8'h00);
        wr(`IRF_OFF_MASK, 8'h05);
        wr(`IRF_OFF_CMD, `IRF_CMD_ENTX);
        wr(`IRF_OFF_OWN, 8'h00);
        rd(`IRF_OFF_MASK, 8'h05, 8'hFF);
        rd(`IRF_OFF_FLAGS, 8'h03, 8'h03);
        @(negedge clk);
        chk("flag pins", {30'h0, receiveInhibitFlag, transmitDoneFlag}, 32'h3);
        wr(`IRF_OFF_OWN, id);
        // prescaler rate under both timing modes
        repeat (4) begin
            tmp = $random(seed);
            wr(`IRF_OFF_CFG, {6'h00, tmp[2], 1'h0});
            wr(`IRF_OFF_SETUP, {6'h00, tmp[1:0]});
            tickGap(10 << tmp[1:0]);
        end
        endSim();
    end
endmodule
`default_nettype wire
